// ### logic/ditd_debounce.sv
`timescale 1ns/1ps
module ditd_debounce #(
    parameter int WIDTH = 10,
    parameter int TW = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ms_tick,
    input wire logic [TW-1:0] filter_ms,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] stable
);

    logic [WIDTH-1:0] stable_q;
    logic [TW-1:0] cnt_q [WIDTH];

    assign stable = stable_q;

    // Counting whole ms ticks keeps each counter narrow; the cost is up to 1 ms of jitter
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                stable_q[i] <= 1'b0;
                cnt_q[i] <= '0;
            end else if (raw[i] == stable_q[i]) begin
                cnt_q[i] <= '0;
            end else if (cnt_q[i] >= filter_ms) begin
                stable_q[i] <= raw[i];
                cnt_q[i] <= '0;
            end else if (ms_tick) begin
                cnt_q[i] <= cnt_q[i] + 1'b1;
            end
        end
    end

endmodule : ditd_debounce

// ### logic/ditd_defines.svh
`ifndef DITD_DEFINES_SVH
`define DITD_DEFINES_SVH

// Timing
`define DITD_CLK_PERIOD_NS 8
`define DITD_TICK_NS 1000000
`define DITD_CYCLES_PER_MS (`DITD_TICK_NS / `DITD_CLK_PERIOD_NS)

// Register byte offsets
`define DITD_REG_MODE 12'h000
`define DITD_REG_DEBOUNCE 12'h004
`define DITD_REG_MAX_FREQ 12'h008
`define DITD_REG_STATUS 12'h00c
`define DITD_REG_RUNTIME 12'h010
`define DITD_REG_FUNC_BASE 12'h040
`define DITD_REG_REF_BASE 12'h080

// Reset values and limits
`define DITD_DEBOUNCE_RST 10'h00a
`define DITD_DEBOUNCE_MAX 10'h3e8
`define DITD_MAX_FREQ_RST 16'h1388
`define DITD_CMD_MODE_RST 2'h0
`define DITD_FULL_SCALE 17'sh003e8

// Terminal command modes
`define DITD_MODE_TWO_1 2'h0
`define DITD_MODE_TWO_2 2'h1
`define DITD_MODE_THREE_1 2'h2
`define DITD_MODE_THREE_2 2'h3

// Input function codes
`define DITD_FN_RUN_A 6'h01
`define DITD_FN_RUN_B 6'h02
`define DITD_FN_THREE_LINE 6'h03
`define DITD_FN_REF_SEL1 6'h0c
`define DITD_FN_RAMP_SEL1 6'h10
`define DITD_FN_MOTOR_SEL1 6'h29
`define DITD_FN_ESTOP 6'h2f
`define DITD_FN_EXT_STOP 6'h30
`define DITD_FN_DC_BRAKE 6'h31
`define DITD_FN_RT_CLEAR 6'h32
`define DITD_FN_LINE_SWAP 6'h33

// Ramp set used by the external stop
`define DITD_RAMP_SET_4 2'h3

`endif

// ### logic/ditd_pkg.sv
package ditd_pkg;

    typedef enum logic [1:0] {
        DITD_DEST_FREQ,
        DITD_DEST_PID,
        DITD_DEST_VF
    } ditd_dest_t;

    typedef enum logic [1:0] {
        DITD_STOP_NONE,
        DITD_STOP_EMERGENCY,
        DITD_STOP_DECEL,
        DITD_STOP_DC_BRAKE
    } ditd_stop_t;

    typedef enum logic [1:0] {
        DITD_RUN_IDLE,
        DITD_RUN_FWD,
        DITD_RUN_REV
    } ditd_run_t;

endpackage : ditd_pkg

// ### logic/ditd_top.sv
`timescale 1ns/1ps
`include "ditd_defines.svh"

module ditd_top
    import ditd_pkg::*;
#(
    parameter int NUM_INPUTS = 10,
    parameter int CYCLES_PER_MS = `DITD_CYCLES_PER_MS,
    parameter int REF_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [NUM_INPUTS-1:0] digital_input,
    output logic run_forward,
    output logic run_reverse,
    output ditd_stop_t stop_request,
    output logic current_limit_hold,
    output logic brake_after_decel,
    output logic runtime_clear,
    output logic [3:0] reference_index,
    output logic [1:0] ramp_set_index,
    output logic [1:0] motor_index,
    output logic signed [REF_W-1:0] frequency_setpoint,
    output logic signed [REF_W-1:0] pid_setpoint,
    output logic signed [REF_W-1:0] vf_voltage_setpoint,
    output logic [31:0] running_time_ms
);

    // Register state
    logic [1:0] cmd_mode_q;
    ditd_dest_t ref_dest_q;
    logic [9:0] input_debounce_time_q;
    logic [15:0] maximum_output_frequency_q;
    logic [5:0] func_sel_q [NUM_INPUTS];
    logic signed [REF_W-1:0] multi_reference_base_q [16];

    // Bus data phase
    logic wr_pend_q;
    logic [11:0] wr_addr_q;
    logic [31:0] hrdata_q;

    // Tick and inputs
    logic [16:0] tick_cnt_q;
    logic ms_tick_q;
    logic [NUM_INPUTS-1:0] din_stable;

    // Decode state
    ditd_run_t run_q;
    logic [1:0] three_start_q;
    logic rt_clear_prev_q;
    logic [31:0] runtime_q;
    logic run_fwd_q;
    logic run_rev_q;
    ditd_stop_t stop_q;
    logic limit_hold_q;
    logic brake_q;
    logic rt_clear_q;
    logic [3:0] ref_idx_q;
    logic [1:0] ramp_idx_q;
    logic [1:0] motor_idx_q;
    logic signed [REF_W-1:0] freq_q;
    logic signed [REF_W-1:0] pid_q;
    logic signed [REF_W-1:0] vf_q;

    // Terminal function lookup; an unassigned code yields off
    function automatic logic fn_on(input logic [5:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NUM_INPUTS; i++) begin
            if (func_sel_q[i] == code && din_stable[i]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction : fn_on

    // Reference scaled so that full scale maps to the maximum frequency
    function automatic logic signed [REF_W-1:0] scale_ref(input logic signed [REF_W-1:0] pct,
                                                          input logic [15:0] fmax);
        logic signed [33:0] prod;
        prod = 34'(pct) * $signed({18'h00000, fmax});
        return REF_W'(prod / 34'(`DITD_FULL_SCALE));
    endfunction : scale_ref

    // AHB-Lite slave: no wait states, always OKAY
    logic addr_valid;
    logic [11:0] addr_lo;
    assign addr_valid = hsel && hready && htrans[1];
    assign addr_lo = haddr[11:0];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 12'h000;
        end else begin
            wr_pend_q <= addr_valid && hwrite;
            wr_addr_q <= addr_lo;
        end
    end

    function automatic logic [31:0] read_reg(input logic [11:0] a);
        logic [31:0] v;
        v = 32'h00000000;
        if (a == `DITD_REG_MODE) begin
            v = {28'h0000000, ref_dest_q, cmd_mode_q};
        end else if (a == `DITD_REG_DEBOUNCE) begin
            v = {22'h000000, input_debounce_time_q};
        end else if (a == `DITD_REG_MAX_FREQ) begin
            v = {16'h0000, maximum_output_frequency_q};
        end else if (a == `DITD_REG_STATUS) begin
            v[31:16] = {motor_idx_q, ramp_idx_q, ref_idx_q, 8'h00};
            v[15:0] = {1'b0, brake_q, stop_q == DITD_STOP_DECEL, stop_q == DITD_STOP_EMERGENCY,
                       run_rev_q, run_fwd_q, 10'(din_stable)};
        end else if (a == `DITD_REG_RUNTIME) begin
            v = runtime_q;
        end else if (a >= `DITD_REG_FUNC_BASE && a < `DITD_REG_FUNC_BASE + 12'(4 * NUM_INPUTS)) begin
            v = {26'h0000000, func_sel_q[4'((a - `DITD_REG_FUNC_BASE) >> 2)]};
        end else if (a >= `DITD_REG_REF_BASE && a < `DITD_REG_REF_BASE + 12'h040) begin
            v = 32'(multi_reference_base_q[4'((a - `DITD_REG_REF_BASE) >> 2)]);
        end
        return v;
    endfunction : read_reg

    // Read data is registered in the address phase so it stands through the data phase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hrdata_q <= 32'h00000000;
        end else if (addr_valid && !hwrite) begin
            hrdata_q <= read_reg(addr_lo);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cmd_mode_q <= `DITD_CMD_MODE_RST;
            ref_dest_q <= DITD_DEST_FREQ;
            input_debounce_time_q <= `DITD_DEBOUNCE_RST;
            maximum_output_frequency_q <= `DITD_MAX_FREQ_RST;
        end else if (wr_pend_q) begin
            if (wr_addr_q == `DITD_REG_MODE) begin
                cmd_mode_q <= hwdata[1:0];
                ref_dest_q <= (hwdata[3:2] == 2'h3) ? DITD_DEST_FREQ : ditd_dest_t'(hwdata[3:2]);
            end else if (wr_addr_q == `DITD_REG_DEBOUNCE) begin
                // Values past one second are clamped
                input_debounce_time_q <= (hwdata[9:0] > `DITD_DEBOUNCE_MAX || hwdata[31:10] != '0) ?
                                         `DITD_DEBOUNCE_MAX : hwdata[9:0];
            end else if (wr_addr_q == `DITD_REG_MAX_FREQ) begin
                maximum_output_frequency_q <= hwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_INPUTS; i++) begin
                func_sel_q[i] <= 6'h00;
            end
        end else if (wr_pend_q && wr_addr_q >= `DITD_REG_FUNC_BASE &&
                     wr_addr_q < `DITD_REG_FUNC_BASE + 12'(4 * NUM_INPUTS)) begin
            func_sel_q[4'((wr_addr_q - `DITD_REG_FUNC_BASE) >> 2)] <= hwdata[5:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 16; i++) begin
                multi_reference_base_q[i] <= '0;
            end
        end else if (wr_pend_q && wr_addr_q >= `DITD_REG_REF_BASE && wr_addr_q < `DITD_REG_REF_BASE + 12'h040) begin
            multi_reference_base_q[4'((wr_addr_q - `DITD_REG_REF_BASE) >> 2)] <= hwdata[REF_W-1:0];
        end
    end

    // Millisecond tick for the filter and the running-time count
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tick_cnt_q <= 17'h00000;
            ms_tick_q <= 1'b0;
        end else if (tick_cnt_q == 17'(CYCLES_PER_MS - 1)) begin
            tick_cnt_q <= 17'h00000;
            ms_tick_q <= 1'b1;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
            ms_tick_q <= 1'b0;
        end
    end

    ditd_debounce #(
        .WIDTH(NUM_INPUTS),
        .TW(10)
    ) u_debounce (
        .clk(clk),
        .reset(reset),
        .ms_tick(ms_tick_q),
        .filter_ms(input_debounce_time_q),
        .raw(digital_input),
        .stable(din_stable)
    );

    // Decoded functions
    logic in_a;
    logic in_b;
    logic in_en;
    logic estop;
    logic ext_stop;
    logic dc_brake;
    logic rt_clear;
    logic [1:0] eff_mode;
    logic [3:0] ref_idx;
    logic [1:0] ramp_idx;
    logic [1:0] motor_idx;

    // A process, not assigns, so that changes in the tables the lookup reads retrigger it
    always_comb begin
        in_a = fn_on(`DITD_FN_RUN_A);
        in_b = fn_on(`DITD_FN_RUN_B);
        in_en = fn_on(`DITD_FN_THREE_LINE);
        estop = fn_on(`DITD_FN_ESTOP);
        ext_stop = fn_on(`DITD_FN_EXT_STOP);
        dc_brake = fn_on(`DITD_FN_DC_BRAKE);
        rt_clear = fn_on(`DITD_FN_RT_CLEAR);
        eff_mode = (cmd_mode_q == `DITD_MODE_TWO_1 && fn_on(`DITD_FN_LINE_SWAP)) ?
                   `DITD_MODE_THREE_1 : cmd_mode_q;
        ref_idx = {fn_on(`DITD_FN_REF_SEL1 + 6'h03), fn_on(`DITD_FN_REF_SEL1 + 6'h02),
                   fn_on(`DITD_FN_REF_SEL1 + 6'h01), fn_on(`DITD_FN_REF_SEL1)};
        ramp_idx = {fn_on(`DITD_FN_RAMP_SEL1 + 6'h01), fn_on(`DITD_FN_RAMP_SEL1)};
        motor_idx = {fn_on(`DITD_FN_MOTOR_SEL1 + 6'h01), fn_on(`DITD_FN_MOTOR_SEL1)};
    end

    // Three-line latch; each start input acts on its own rising edge, so a held one blocks no other
    logic any_stop;
    assign any_stop = estop || ext_stop || dc_brake;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_q <= DITD_RUN_IDLE;
            three_start_q <= 2'h0;
        end else begin
            three_start_q <= {in_b, in_a};
            if (any_stop || !in_en || !eff_mode[1]) begin
                run_q <= DITD_RUN_IDLE;
            end else if (eff_mode == `DITD_MODE_THREE_1) begin
                if (in_a && !three_start_q[0]) begin
                    run_q <= DITD_RUN_FWD;
                end else if (in_b && !three_start_q[1]) begin
                    run_q <= DITD_RUN_REV;
                end
            end else if (in_a && !three_start_q[0]) begin
                run_q <= DITD_RUN_FWD;
            end
        end
    end

    // Run command per mode
    logic fwd_d;
    logic rev_d;
    always_comb begin
        fwd_d = 1'b0;
        rev_d = 1'b0;
        case (eff_mode)
            `DITD_MODE_TWO_1: begin
                fwd_d = in_a && !in_b;
                rev_d = in_b && !in_a;
            end
            `DITD_MODE_TWO_2: begin
                fwd_d = in_a && !in_b;
                rev_d = in_a && in_b;
            end
            `DITD_MODE_THREE_1: begin
                fwd_d = in_en && run_q == DITD_RUN_FWD;
                rev_d = in_en && run_q == DITD_RUN_REV;
            end
            default: begin
                fwd_d = in_en && run_q != DITD_RUN_IDLE && !in_b;
                rev_d = in_en && run_q != DITD_RUN_IDLE && in_b;
            end
        endcase
    end

    // Stop requests with emergency stop first
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            run_fwd_q <= 1'b0;
            run_rev_q <= 1'b0;
            stop_q <= DITD_STOP_NONE;
            limit_hold_q <= 1'b0;
            brake_q <= 1'b0;
        end else begin
            run_fwd_q <= fwd_d && !any_stop;
            run_rev_q <= rev_d && !any_stop;
            limit_hold_q <= estop;
            brake_q <= dc_brake && !estop;
            if (estop) begin
                stop_q <= DITD_STOP_EMERGENCY;
            end else if (ext_stop) begin
                stop_q <= DITD_STOP_DECEL;
            end else if (dc_brake) begin
                stop_q <= DITD_STOP_DC_BRAKE;
            end else begin
                stop_q <= DITD_STOP_NONE;
            end
        end
    end

    // Running-time accumulator; a clear edge wins over the tick in the same cycle
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rt_clear_prev_q <= 1'b0;
            rt_clear_q <= 1'b0;
            runtime_q <= 32'h00000000;
        end else begin
            rt_clear_prev_q <= rt_clear;
            rt_clear_q <= rt_clear && !rt_clear_prev_q;
            if (rt_clear && !rt_clear_prev_q) begin
                runtime_q <= 32'h00000000;
            end else if (ms_tick_q && (run_fwd_q || run_rev_q)) begin
                runtime_q <= runtime_q + 32'h00000001;
            end
        end
    end

    // Selection indices and setpoints
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_idx_q <= 4'h0;
            ramp_idx_q <= 2'h0;
            motor_idx_q <= 2'h0;
            freq_q <= '0;
            pid_q <= '0;
            vf_q <= '0;
        end else begin
            ref_idx_q <= ref_idx;
            ramp_idx_q <= ext_stop ? `DITD_RAMP_SET_4 : ramp_idx;
            motor_idx_q <= motor_idx;
            freq_q <= (ref_dest_q == DITD_DEST_FREQ) ?
                      scale_ref(multi_reference_base_q[ref_idx], maximum_output_frequency_q) : '0;
            pid_q <= (ref_dest_q == DITD_DEST_PID) ? multi_reference_base_q[ref_idx] : '0;
            vf_q <= (ref_dest_q == DITD_DEST_VF) ? multi_reference_base_q[ref_idx] : '0;
        end
    end

    assign run_forward = run_fwd_q;
    assign run_reverse = run_rev_q;
    assign stop_request = stop_q;
    assign current_limit_hold = limit_hold_q;
    assign brake_after_decel = brake_q;
    assign runtime_clear = rt_clear_q;
    assign reference_index = ref_idx_q;
    assign ramp_set_index = ramp_idx_q;
    assign motor_index = motor_idx_q;
    assign frequency_setpoint = freq_q;
    assign pid_setpoint = pid_q;
    assign vf_voltage_setpoint = vf_q;
    assign running_time_ms = runtime_q;

endmodule : ditd_top

// ### sim/ditd_switches.sv
`timescale 1ns/1ps
module ditd_switches (
    input wire logic clk,
    input wire logic [9:0] want,
    input wire logic [9:0] glitch,
    output logic [9:0] din
);
    logic [9:0] last_q;
    logic [1:0] chat_q;
    initial begin
        din = 10'h000;
        last_q = 10'h000;
        chat_q = 2'h0;
    end
    // Contacts chatter for three cycles after every change; the filter has to ride over it
    always @(posedge clk) begin
        last_q <= want;
        if (want != last_q) chat_q <= 2'h3;
        else if (chat_q != 2'h0) chat_q <= chat_q - 2'h1;
        din <= (chat_q[0] ? ~want : want) ^ glitch;
    end
endmodule : ditd_switches

// ### sim/ditd_top_assertions.sv
`timescale 1ns/1ps
module ditd_top_checker
    import ditd_pkg::*;
#(
    parameter int REF_W = 16
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic run_forward,
    input wire logic run_reverse,
    input ditd_stop_t stop_request,
    input wire logic current_limit_hold,
    input wire logic brake_after_decel,
    input wire logic runtime_clear,
    input wire logic [1:0] ramp_set_index,
    input wire logic signed [REF_W-1:0] frequency_setpoint,
    input wire logic signed [REF_W-1:0] pid_setpoint,
    input wire logic signed [REF_W-1:0] vf_voltage_setpoint,
    input wire logic [31:0] running_time_ms
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_estop_hold;
        $rose(current_limit_hold) |-> stop_request == DITD_STOP_EMERGENCY ##1 current_limit_hold;
    endproperty
    a_estop_hold: assert property (p_estop_hold) else $error("current hold without emergency stop");
    property p_stop_quiet;
        stop_request != DITD_STOP_NONE |-> !run_forward && !run_reverse;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("run command during stop");
    property p_one_dir;
        !(run_forward && run_reverse);
    endproperty
    a_one_dir: assert property (p_one_dir) else $error("both directions commanded");
    property p_ext_ramp;
        stop_request == DITD_STOP_DECEL |-> ramp_set_index == 2'h3;
    endproperty
    a_ext_ramp: assert property (p_ext_ramp) else $error("external stop not on ramp set four");
    property p_brake_yield;
        brake_after_decel |-> stop_request != DITD_STOP_EMERGENCY && stop_request != DITD_STOP_NONE;
    endproperty
    a_brake_yield: assert property (p_brake_yield) else $error("braking request out of turn");
    property p_clear_pulse;
        runtime_clear |=> !runtime_clear;
    endproperty
    a_clear_pulse: assert property (p_clear_pulse) else $error("clear pulse too long");
    property p_clear_zero;
        runtime_clear |-> ##[0:2] running_time_ms == 32'h0;
    endproperty
    a_clear_zero: assert property (p_clear_zero) else $error("running time not cleared");
    property p_rt_step;
        1'b1 |=> running_time_ms == $past(running_time_ms) || running_time_ms == $past(running_time_ms) + 32'h1
            || running_time_ms == 32'h0;
    endproperty
    a_rt_step: assert property (p_rt_step) else $error("running time jumped");
    property p_bus_okay;
        hreadyout && !hresp;
    endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("bus response not okay");
    property p_dest_excl;
        pid_setpoint != 0 |-> frequency_setpoint == 0 && vf_voltage_setpoint == 0;
    endproperty
    a_dest_excl: assert property (p_dest_excl) else $error("reference routed twice");
endmodule : ditd_top_checker

bind ditd_top ditd_top_checker #(.REF_W(REF_W)) u_chk (.clk(clk), .reset(reset), .hreadyout(hreadyout),
    .hresp(hresp), .run_forward(run_forward), .run_reverse(run_reverse), .stop_request(stop_request),
    .current_limit_hold(current_limit_hold), .brake_after_decel(brake_after_decel),
    .runtime_clear(runtime_clear), .ramp_set_index(ramp_set_index), .frequency_setpoint(frequency_setpoint),
    .pid_setpoint(pid_setpoint), .vf_voltage_setpoint(vf_voltage_setpoint), .running_time_ms(running_time_ms));

// ### sim/ditd_top_tb.sv
`timescale 1ns/1ps
`include "ditd_defines.svh"
module ditd_top_tb;
    import ditd_pkg::*;
    localparam int CPM = 4;
    localparam int DB = 2;
    localparam int SETTLE = (DB + 2) * CPM + 8;
    logic clk, reset, hsel, hwrite, hready, hreadyout, hresp;
    logic [1:0] htrans, ramp_set_index, motor_index;
    logic [2:0] hsize;
    logic [3:0] reference_index;
    logic [31:0] haddr, hwdata, hrdata, running_time_ms, rd;
    logic [9:0] want, glitch, din, stopmask;
    logic run_forward, run_reverse, current_limit_hold, brake_after_decel, runtime_clear;
    ditd_stop_t stop_request;
    logic signed [15:0] frequency_setpoint, pid_setpoint, vf_voltage_setpoint;
    int n_errors, checks, lat, mode, swap, pa, pb, clr_seen, fmax, r;
    int refs [16];
    int fa [10] = '{1, 2, 3, 12, 13, 14, 15, 16, 17, 47};
    int fb [10] = '{1, 2, 3, 41, 42, 48, 49, 50, 51, 47};
    int sw [6] = '{'h100, 'h101, 'h104, 'h105, 'h104, 'h100};
    assign hready = hreadyout;
    ditd_top #(.CYCLES_PER_MS(CPM)) DUT (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .digital_input(din), .run_forward(run_forward), .run_reverse(run_reverse),
        .stop_request(stop_request), .current_limit_hold(current_limit_hold),
        .brake_after_decel(brake_after_decel), .runtime_clear(runtime_clear), .reference_index(reference_index),
        .ramp_set_index(ramp_set_index), .motor_index(motor_index), .frequency_setpoint(frequency_setpoint),
        .pid_setpoint(pid_setpoint), .vf_voltage_setpoint(vf_voltage_setpoint), .running_time_ms(running_time_ms));
    ditd_switches u_sw (.clk(clk), .want(want), .glitch(glitch), .din(din));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) if (runtime_clear === 1'b1) clr_seen <= clr_seen + 1;

    task automatic end_sim;
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t register read %h expected %h", $time, got, exp);
        end
    endtask : chk_reg
    task automatic chk_port(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t output %h expected %h", $time, got, exp);
        end
    endtask : chk_port
    // Master never assumes a latency: it waits on hready for both phases
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk_reg(rd, exp);
    endtask : rdchk
    // Reference model of the run decoding, advanced once per settled input pattern
    task automatic step(input logic [9:0] w);
        int a, b, c, e;
        a = int'(w[0]);
        b = int'(w[1]);
        c = int'(w[2]);
        e = (mode == 0 && swap != 0) ? 2 : mode;
        want <= w;
        repeat (SETTLE) @(posedge clk);
        if (e == 0) lat = (a && !b) ? 1 : (b && !a) ? 2 : 0;
        else if (e == 1) lat = a ? (b ? 2 : 1) : 0;
        else if (c == 0) lat = 0;
        else if (e == 2 && a && !pa) lat = 1;
        else if (e == 2 && b && !pb) lat = 2;
        else if (e == 3 && a && !pa) lat = 1;
        if (e == 3 && lat != 0) lat = b ? 2 : 1;
        if ((w & stopmask) != 0) lat = 0;
        pa = a;
        pb = b;
        chk_port({run_forward, run_reverse}, {lat == 1, lat == 2});
    endtask : step

    initial begin
        #400000;
        n_errors++;
        end_sim;
    end
    initial begin
        reset = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        want = 10'h000;
        glitch = 10'h000;
        {n_errors, checks, lat, mode, swap, pa, pb, clr_seen} = '0;
        stopmask = 10'h200;
        void'($urandom(46));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rdchk(`DITD_REG_MODE, 32'h0);
        rdchk(`DITD_REG_DEBOUNCE, 32'd10);
        rdchk(`DITD_REG_MAX_FREQ, 32'h1388);
        rdchk(`DITD_REG_FUNC_BASE + 32'h24, 32'h0);
        rdchk(32'h100, 32'h0);
        bus(1'b1, `DITD_REG_DEBOUNCE, 32'd2000);
        rdchk(`DITD_REG_DEBOUNCE, 32'd1000);
        bus(1'b1, `DITD_REG_DEBOUNCE, DB);
        for (int i = 0; i < 10; i++) bus(1'b1, `DITD_REG_FUNC_BASE + 4 * i, fa[i]);
        for (int m = 0; m < 4; m++) begin
            step(10'h000);
            mode = m;
            bus(1'b1, `DITD_REG_MODE, m);
            for (int i = 0; i < 12; i++) step(10'($urandom % 8));
        end
        step(10'h000);
        mode = 0;
        bus(1'b1, `DITD_REG_MODE, 0);
        fmax = 1000 + $urandom % 31000;
        bus(1'b1, `DITD_REG_MAX_FREQ, fmax);
        for (int i = 0; i < 16; i++) begin
            refs[i] = $urandom % 1001;
            bus(1'b1, `DITD_REG_REF_BASE + 4 * i, refs[i]);
        end
        for (int i = 0; i < 16; i++) begin
            r = $urandom % 4;
            step(10'((i << 3) | (r << 7)));
            chk_port(reference_index, i);
            chk_port(ramp_set_index, r);
            chk_port(motor_index, 0);
            chk_port(frequency_setpoint, refs[i] * fmax / 1000);
        end
        for (int d = 1; d < 3; d++) begin
            bus(1'b1, `DITD_REG_MODE, d << 2);
            repeat (3) @(posedge clk);
            chk_port(pid_setpoint, d == 1 ? refs[15] : 0);
            chk_port(vf_voltage_setpoint, d == 2 ? refs[15] : 0);
            chk_port(frequency_setpoint, 0);
        end
        bus(1'b1, `DITD_REG_MODE, 0);
        step(10'h000);
        // A one-cycle spike must be filtered out, and a hold must not pass before the filter time has run
        glitch <= 10'h200;
        @(posedge clk);
        glitch <= 10'h000;
        repeat (SETTLE) @(posedge clk);
        chk_port(stop_request, DITD_STOP_NONE);
        want <= 10'h201;
        repeat (DB * CPM - 2) @(posedge clk);
        chk_port(stop_request, DITD_STOP_NONE);
        step(10'h201);
        chk_port({stop_request, current_limit_hold}, {DITD_STOP_EMERGENCY, 1'b1});
        step(10'h000);
        stopmask = 10'h260;
        for (int i = 0; i < 10; i++) bus(1'b1, `DITD_REG_FUNC_BASE + 4 * i, fb[i]);
        for (int i = 0; i < 4; i++) begin
            step(10'(i << 3));
            chk_port({motor_index, reference_index}, {2'(i), 4'h0});
        end
        step(10'h021);
        chk_port({stop_request, ramp_set_index}, {DITD_STOP_DECEL, 2'h3});
        step(10'h040);
        chk_port({stop_request, brake_after_decel}, {DITD_STOP_DC_BRAKE, 1'b1});
        step(10'h260);
        chk_port({stop_request, brake_after_decel}, {DITD_STOP_EMERGENCY, 1'b0});
        rdchk(`DITD_REG_STATUS, 32'h30001260);
        step(10'h001);
        repeat (200) @(posedge clk);
        chk_port(running_time_ms > 40, 1);
        clr_seen = 0;
        step(10'h081);
        chk_port(clr_seen, 1);
        chk_port(running_time_ms <= SETTLE / CPM + 1, 1);
        step(10'h000);
        swap = 1;
        for (int i = 0; i < 6; i++) step(10'(sw[i]));
        swap = 0;
        step(10'h000);
        end_sim;
    end
endmodule : ditd_top_tb
